// File: hdl/eag_pkg.sv
// package for the effective address generator
package eag_pkg;
  localparam int ADDR_W = 24;
  localparam int OFS_W = 16;
  localparam int BANK_W = 8;
  localparam logic [7:0] BANK_ZERO = 8'h00;
  localparam logic [23:0] VEC_LOW = 24'h00_FFE0;
  localparam logic [23:0] VEC_HIGH = 24'h00_FFFF;
  localparam logic [15:0] PC_STEP_MOVE = 16'h0003;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [1:0] VEC_PULL_CYCLES = 2'h2;

  typedef enum logic [4:0] {
    EAG_ABS, EAG_ABS_X, EAG_ABS_Y, EAG_ABS_IND, EAG_ABS_IDX_IND, EAG_ABS_LONG,
    EAG_ABS_LONG_X, EAG_JUMP_LONG_IND, EAG_DIR, EAG_DIR_X, EAG_DIR_Y,
    EAG_DIR_X_IND, EAG_DIR_IND, EAG_DIR_IND_Y, EAG_DIR_IND_LONG,
    EAG_DIR_IND_LONG_Y, EAG_IMM, EAG_STACK, EAG_STACK_REL, EAG_VECTOR,
    EAG_MOVE_ASC, EAG_MOVE_DESC, EAG_RELATIVE, EAG_NONE
  } eag_mode_type;

  typedef struct packed {
    logic [7:0] op2;
    logic [7:0] op3;
    logic [7:0] op4;
  } eag_operand_type;

  typedef struct packed {
    logic [15:0] idx_x;
    logic [15:0] idx_y;
    logic [15:0] direct;
    logic [15:0] stack;
    logic [15:0] acc;
    logic [7:0] data_bank;
    logic [7:0] program_bank;
    logic [15:0] code_pointer;
  } eag_regs_type;

  typedef struct packed {
    logic [7:0] bank;
    logic [15:0] offset;
  } eag_addr_type;
endpackage

// File: hdl/eag_vector_pull.sv
// vector pull timer for interrupt vector fetch cycles
`timescale 1ns/1ps
`default_nettype none
module eag_vector_pull
  import eag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic vector_start,
  input wire logic step,
  output logic vector_pull_n,
  output logic vector_active
);
  logic [1:0] count_reg;
  logic [1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (vector_start) begin
      count_next = VEC_PULL_CYCLES;
    end else if (step && (count_reg != 2'h0)) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_reg <= 2'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  // low for exactly two bus cycles
  assign vector_active = (count_reg != 2'h0);
  assign vector_pull_n = ~vector_active;
endmodule
`default_nettype wire

// File: hdl/eag_core.sv
// effective address generator datapath
// Function
// - vector pull low for final two cycles
// - addresses span flat 16 MByte space
// - vectors fetched from 00FFE0 to 00FFFF
// - stack modes forced into bank zero
// - direct, direct X and direct Y modes yield bank zero
// - listed modes and wraps keep program bank
// - only five instructions change program bank
// - data addresses computed as full 24 bits
// - absolute uses operand offset, data bank
// - indexed indirect jump pointer in bank zero
// - absolute indexed adds index, data bank
// - indirect pointer bank zero, long loads bank
// - long address plus optional first index
// - block move banks, offsets and count
// - block step moves indexes, count, pointer
// - direct indexed indirect pointer, data bank
// - direct indexed sum in bank zero
// - indirect indexed base plus second index
// - indirect long pointer plus optional index
// - direct indirect pointer with data bank
// - direct adds base, extra cycle if unaligned
// - immediate operand one or two bytes
`timescale 1ns/1ps
`default_nettype none
module eag_core
  import eag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic addr_req,
  input wire eag_mode_type mode,
  input wire eag_operand_type operand,
  input wire eag_regs_type regs_in,
  input wire logic load_regs,
  input wire logic [23:0] pointer_data,
  input wire logic wide_operand,
  input wire logic [3:0] vector_select,
  input wire logic vector_start,
  input wire logic bus_step,
  input wire logic code_advance,
  input wire logic program_bank_load,
  input wire logic [7:0] program_bank_value,
  output eag_addr_type eff_addr,
  output logic addr_valid,
  output eag_addr_type pointer_addr,
  output logic [15:0] immediate_value,
  output logic extra_cycle,
  output eag_regs_type regs_out,
  output logic move_done,
  output logic vector_pull_n
);
  ////////////////////////////////////////////////////////////////////////
  // address helpers
  function automatic logic [15:0] wrap16(input logic [15:0] a, input logic [15:0] b);
    wrap16 = a + b;
  endfunction

  function automatic logic [23:0] add24(input logic [23:0] base, input logic [15:0] idx);
    add24 = base + {ZERO8, idx};
  endfunction

  function automatic logic [15:0] zext8(input logic [7:0] v);
    zext8 = {ZERO8, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // working register copy
  eag_regs_type regs_reg;
  eag_regs_type regs_next;
  eag_addr_type eff_reg;
  eag_addr_type eff_next;
  eag_addr_type ptr_reg;
  eag_addr_type ptr_next;
  logic valid_reg;
  logic valid_next;
  logic [15:0] imm_reg;
  logic [15:0] imm_next;
  logic extra_reg;
  logic extra_next;
  logic done_reg;
  logic done_next;
  logic vector_active;

  logic [15:0] operand16;
  logic [23:0] operand24;
  logic [15:0] direct_ptr;
  logic [15:0] direct_x;
  logic [15:0] direct_y;
  logic [15:0] direct_x_ptr;
  logic [23:0] vector_addr;

  assign operand16 = {operand.op3, operand.op2};
  assign operand24 = {operand.op4, operand.op3, operand.op2};
  assign direct_ptr = wrap16(regs_reg.direct, zext8(operand.op2));
  assign direct_x = wrap16(direct_ptr, regs_reg.idx_x);
  assign direct_y = wrap16(direct_ptr, regs_reg.idx_y);
  assign direct_x_ptr = direct_x;
  // vector slot within the fixed top of bank zero
  assign vector_addr = VEC_LOW | {19'h0_0000, vector_select, 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // address formation
  always_comb begin
    regs_next = regs_reg;
    eff_next = eff_reg;
    ptr_next = ptr_reg;
    valid_next = 1'b0;
    imm_next = imm_reg;
    extra_next = extra_reg;
    done_next = 1'b0;
    if (load_regs) begin
      regs_next = regs_in;
    end
    if (addr_req) begin
      valid_next = 1'b1;
      extra_next = 1'b0;
      unique case (mode)
        EAG_ABS: eff_next = {regs_reg.data_bank, operand16};
        EAG_ABS_X: eff_next = add24({regs_reg.data_bank, operand16}, regs_reg.idx_x);
        EAG_ABS_Y: eff_next = add24({regs_reg.data_bank, operand16}, regs_reg.idx_y);
        EAG_ABS_IND, EAG_JUMP_LONG_IND: begin
          ptr_next = {BANK_ZERO, operand16};
          eff_next = {regs_reg.program_bank, pointer_data[15:0]};
          if (mode == EAG_JUMP_LONG_IND) begin
            eff_next.bank = pointer_data[23:16];
            regs_next.program_bank = pointer_data[23:16];
          end
          regs_next.code_pointer = pointer_data[15:0];
        end
        EAG_ABS_IDX_IND: begin
          ptr_next = {BANK_ZERO, wrap16(operand16, regs_reg.idx_x)};
          eff_next = {regs_reg.program_bank, pointer_data[15:0]};
          regs_next.code_pointer = pointer_data[15:0];
        end
        EAG_ABS_LONG: eff_next = operand24;
        EAG_ABS_LONG_X: eff_next = add24(operand24, regs_reg.idx_x);
        EAG_DIR: begin
          eff_next = {BANK_ZERO, direct_ptr};
          extra_next = (regs_reg.direct[7:0] != ZERO8);
        end
        EAG_DIR_X: eff_next = {BANK_ZERO, direct_x};
        EAG_DIR_Y: eff_next = {BANK_ZERO, direct_y};
        EAG_DIR_X_IND: begin
          ptr_next = {BANK_ZERO, direct_x_ptr};
          eff_next = {regs_reg.data_bank, pointer_data[15:0]};
        end
        EAG_DIR_IND: begin
          ptr_next = {BANK_ZERO, direct_ptr};
          eff_next = {regs_reg.data_bank, pointer_data[15:0]};
        end
        EAG_DIR_IND_Y: begin
          ptr_next = {BANK_ZERO, direct_ptr};
          eff_next = add24({regs_reg.data_bank, pointer_data[15:0]}, regs_reg.idx_y);
        end
        EAG_DIR_IND_LONG: begin
          ptr_next = {BANK_ZERO, direct_ptr};
          eff_next = pointer_data;
        end
        EAG_DIR_IND_LONG_Y: begin
          ptr_next = {BANK_ZERO, direct_ptr};
          eff_next = add24(pointer_data, regs_reg.idx_y);
        end
        EAG_IMM: begin
          imm_next = wide_operand ? operand16 : zext8(operand.op2);
          eff_next = {regs_reg.program_bank, regs_reg.code_pointer};
        end
        EAG_STACK: eff_next = {BANK_ZERO, regs_reg.stack};
        EAG_STACK_REL: eff_next = {BANK_ZERO, wrap16(regs_reg.stack, zext8(operand.op2))};
        EAG_VECTOR: eff_next = vector_addr;
        EAG_MOVE_ASC, EAG_MOVE_DESC: begin
          regs_next.data_bank = operand.op2;
          ptr_next = {operand.op3, regs_reg.idx_x};
          eff_next = {operand.op2, regs_reg.idx_y};
          if (mode == EAG_MOVE_ASC) begin
            regs_next.idx_x = regs_reg.idx_x + ONE16;
            regs_next.idx_y = regs_reg.idx_y + ONE16;
          end else begin
            regs_next.idx_x = regs_reg.idx_x - ONE16;
            regs_next.idx_y = regs_reg.idx_y - ONE16;
          end
          regs_next.acc = regs_reg.acc - ONE16;
          if (regs_reg.acc == 16'h0000) begin
            done_next = 1'b1;
            regs_next.code_pointer = regs_reg.code_pointer + PC_STEP_MOVE;
          end
        end
        EAG_RELATIVE: eff_next = {regs_reg.program_bank, regs_reg.code_pointer};
        EAG_NONE: valid_next = 1'b0;
        default: valid_next = 1'b0;
      endcase
    end
    // code pointer wraps inside its bank
    if (code_advance) begin
      regs_next.code_pointer = regs_reg.code_pointer + ONE16;
    end
    // only long returns, calls and jumps load a bank
    if (program_bank_load) begin
      regs_next.program_bank = program_bank_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regs_reg <= '0;
      eff_reg <= '0;
      ptr_reg <= '0;
      valid_reg <= 1'b0;
      imm_reg <= 16'h0000;
      extra_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      eff_reg <= eff_next;
      ptr_reg <= ptr_next;
      valid_reg <= valid_next;
      imm_reg <= imm_next;
      extra_reg <= extra_next;
      done_reg <= done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vector pull
  eag_vector_pull u_vector_pull (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .vector_start(vector_start),
    .step(bus_step),
    .vector_pull_n(vector_pull_n),
    .vector_active(vector_active)
  );

  assign eff_addr = eff_reg;
  assign addr_valid = valid_reg;
  assign pointer_addr = ptr_reg;
  assign immediate_value = imm_reg;
  assign extra_cycle = extra_reg;
  assign regs_out = regs_reg;
  assign move_done = done_reg;
endmodule
`default_nettype wire

// File: bench/eag_mem_model.sv
// memory model answering pointer reads
`timescale 1ns/1ps
`default_nettype none
module eag_mem_model (
  input wire logic [23:0] addr,
  output logic [23:0] data
);
  // contents follow only the low 16 address bits, so a wrong pointer offset shows
  assign data = {addr[7:0] ^ 8'h5A, addr[15:0] ^ 16'hC3A5};
endmodule
`default_nettype wire

// File: bench/eag_core_checker.sv
// assertions on the effective address generator ports
`timescale 1ns/1ps
`default_nettype none
module eag_core_checker
  import eag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic addr_req,
  input wire eag_mode_type mode,
  input wire eag_operand_type operand,
  input wire logic load_regs,
  input wire logic vector_start,
  input wire logic program_bank_load,
  input wire eag_addr_type eff_addr,
  input wire logic extra_cycle,
  input wire eag_regs_type regs_out,
  input wire logic move_done,
  input wire logic vector_pull_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_pull; vector_start |=> !vector_pull_n; endproperty
  a_pull: assert property (p_pull) else $error("pull not low");
  property p_dir; addr_req && mode inside {EAG_DIR, EAG_DIR_X, EAG_DIR_Y}
    |=> eff_addr.bank == BANK_ZERO; endproperty
  a_dir: assert property (p_dir) else $error("direct bank");
  property p_stk; addr_req && mode inside {EAG_STACK, EAG_STACK_REL}
    |=> eff_addr.bank == BANK_ZERO; endproperty
  a_stk: assert property (p_stk) else $error("stack bank");
  property p_vec; addr_req && mode == EAG_VECTOR
    |=> eff_addr >= VEC_LOW && eff_addr <= VEC_HIGH; endproperty
  a_vec: assert property (p_vec) else $error("vector range");
  property p_abs; addr_req && mode == EAG_ABS && !load_regs
    |=> eff_addr == {regs_out.data_bank, $past(operand.op3), $past(operand.op2)}; endproperty
  a_abs: assert property (p_abs) else $error("absolute address");
  property p_pb; !load_regs && !program_bank_load && !(addr_req && mode == EAG_JUMP_LONG_IND)
    |=> $stable(regs_out.program_bank); endproperty
  a_pb: assert property (p_pb) else $error("program bank moved");
  property p_cp3; move_done
    |-> regs_out.code_pointer == $past(regs_out.code_pointer) + PC_STEP_MOVE; endproperty
  a_cp3: assert property (p_cp3) else $error("move step");
  property p_ext; addr_req && mode == EAG_DIR && !load_regs
    |=> extra_cycle == (regs_out.direct[7:0] != ZERO8); endproperty
  a_ext: assert property (p_ext) else $error("extra cycle");
endmodule
bind eag_core eag_core_checker i_eag_core_checker (.core_clk, .rst_n, .addr_req, .mode,
  .operand, .load_regs, .vector_start, .program_bank_load, .eff_addr, .extra_cycle,
  .regs_out, .move_done, .vector_pull_n);
`default_nettype wire

// File: bench/tb_eag_core.sv
// self-checking bench for the effective address generator
`timescale 1ns/1ps
`default_nettype none
module tb_eag_core
  import eag_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, addr_req = 1'b0, load_regs = 1'b0;
  logic wide_operand = 1'b0, vector_start = 1'b0, bus_step = 1'b0;
  logic code_advance = 1'b0, program_bank_load = 1'b0;
  logic [7:0] program_bank_value = 8'h56;
  logic [3:0] vector_select = 4'h0;
  logic [23:0] ptr_loc = 24'h00_0000, pointer_data, full_pc;
  eag_mode_type mode = EAG_NONE;
  eag_operand_type operand = 24'h00_0000;
  eag_regs_type regs_in = '0, regs_out;
  eag_regs_type r0 = '{16'h0020, 16'h0105, 16'h12F0, 16'h01F0, 16'h0001, 8'h12, 8'h34, 16'hFFFF};
  eag_regs_type r1 = '{16'h1000, 16'h2000, 16'hFF00, 16'h01F0, 16'h0001, 8'h12, 8'h34, 16'hFFFE};
  eag_addr_type eff_addr, pointer_addr;
  logic addr_valid, extra_cycle, move_done, vector_pull_n;
  logic [15:0] immediate_value;
  int n_mismatch = 0, checked = 0;
  assign full_pc = {regs_out.program_bank, regs_out.code_pointer};
  always #12.5 core_clk = ~core_clk;
  eag_core i_eag_core (.core_clk, .rst_n, .addr_req, .mode, .operand, .regs_in, .load_regs,
    .pointer_data, .wide_operand, .vector_select, .vector_start, .bus_step, .code_advance,
    .program_bank_load, .program_bank_value, .eff_addr, .addr_valid, .pointer_addr,
    .immediate_value, .extra_cycle, .regs_out, .move_done, .vector_pull_n);
  eag_mem_model i_eag_mem_model (.addr(ptr_loc), .data(pointer_data));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic load(input eag_regs_type r);
    regs_in = r;
    pulse(load_regs);
  endtask
  task automatic req(input eag_mode_type m, input logic [23:0] ops);
    @(negedge core_clk);
    mode = m;
    operand = ops;
    addr_req = 1'b1;
    @(negedge core_clk);
    addr_req = 1'b0;
    chk("addr_valid", 24'h00_0001, 24'(addr_valid));
  endtask
  task automatic t_abs;
    eag_mode_type m [5] = '{EAG_ABS, EAG_ABS_X, EAG_ABS_Y, EAG_ABS_LONG, EAG_ABS_LONG_X};
    logic [23:0] e [5] = '{24'h12_FFF0, 24'h13_0010, 24'h13_00F5, 24'h7E_FFF0, 24'h7F_0010};
    load(r0);
    for (int i = 0; i < 5; i++) begin
      req(m[i], 24'hF0_FF7E);
      chk("abs", e[i], eff_addr);
    end
    $display("abs done");
  endtask
  task automatic t_dir;
    req(EAG_DIR, 24'h20_0000);
    chk("dir", 24'h01_1310, {7'h0, extra_cycle, eff_addr.offset});
    req(EAG_DIR_X, 24'h20_0000);
    chk("dir x", 24'h00_1330, eff_addr);
    req(EAG_STACK_REL, 24'h20_0000);
    chk("stack rel", 24'h00_0210, eff_addr);
    load(r1);
    req(EAG_DIR, 24'h20_0000);
    chk("extra", 24'h00_0000, 24'(extra_cycle));
    req(EAG_DIR_Y, 24'h20_0000);
    chk("dir y", 24'h00_1F20, eff_addr);
    $display("dir done");
  endtask
  task automatic t_ind;
    eag_mode_type m [5] = '{EAG_DIR_IND, EAG_DIR_IND_Y, EAG_DIR_IND_LONG,
      EAG_DIR_IND_LONG_Y, EAG_DIR_X_IND};
    logic [23:0] e;
    load(r0);
    for (int i = 0; i < 5; i++) begin
      ptr_loc = (i == 4) ? 24'h00_1330 : 24'h00_1310;
      req(m[i], 24'h20_0000);
      e = (i == 2 || i == 3) ? pointer_data : {8'h12, pointer_data[15:0]};
      e = e + ((i == 1 || i == 3) ? 24'h00_0105 : 24'h00_0000);
      chk("indirect", e, eff_addr);
    end
    $display("ind done");
  endtask
  task automatic t_jump;
    load(r0);
    pulse(code_advance);
    chk("code wrap", 24'h34_0000, full_pc);
    ptr_loc = 24'h00_0010;
    req(EAG_ABS_IDX_IND, 24'hF0_FF00);
    chk("idx ptr", 24'h00_0010, pointer_addr);
    chk("idx jump", {8'h34, pointer_data[15:0]}, full_pc);
    ptr_loc = 24'h00_FFF0;
    req(EAG_ABS_IND, 24'hF0_FF00);
    chk("ind jump", {8'h34, pointer_data[15:0]}, full_pc);
    req(EAG_JUMP_LONG_IND, 24'hF0_FF00);
    chk("long jump", pointer_data, full_pc);
    pulse(program_bank_load);
    chk("bank load", 24'h56_3C55, full_pc);
    req(EAG_RELATIVE, 24'h00_0000);
    chk("relative", 24'h56_3C55, eff_addr);
    @(negedge core_clk);
    mode = EAG_NONE;
    addr_req = 1'b1;
    @(negedge core_clk);
    addr_req = 1'b0;
    chk("refused", 24'h00_0000, 24'(addr_valid));
    $display("jump done");
  endtask
  task automatic t_imm_vec;
    req(EAG_IMM, 24'hA5_C300);
    chk("imm", 24'h00_00A5, 24'(immediate_value));
    wide_operand = 1'b1;
    req(EAG_IMM, 24'hA5_C300);
    chk("imm wide", 24'h00_C3A5, 24'(immediate_value));
    for (int s = 0; s < 16; s++) begin
      vector_select = 4'(s);
      req(EAG_VECTOR, 24'h00_0000);
      chk("vector", VEC_LOW | 24'(2 * s), eff_addr);
    end
    pulse(vector_start);
    chk("pull", 24'h00_0000, 24'(vector_pull_n));
    pulse(bus_step);
    chk("pull", 24'h00_0000, 24'(vector_pull_n));
    pulse(bus_step);
    chk("pull end", 24'h00_0001, 24'(vector_pull_n));
    $display("imm vec done");
  endtask
  task automatic t_move;
    load(r1);
    req(EAG_MOVE_ASC, 24'h7E_5500);
    chk("dest", 24'h7E_2000, eff_addr);
    chk("src", 24'h55_1000, pointer_addr);
    chk("step", 24'h01_2001, {regs_out.idx_x[7:0], regs_out.idx_y});
    chk("count", 24'h7E_0000, {regs_out.data_bank, regs_out.acc});
    req(EAG_MOVE_ASC, 24'h7E_5500);
    chk("end", 24'h01_0001, {7'h0, move_done, regs_out.code_pointer});
    load(r1);
    req(EAG_MOVE_DESC, 24'h7E_5500);
    chk("down", 24'h0F_FFFF, {regs_out.idx_x, regs_out.idx_y[7:0]});
    $display("move done");
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk("reset", 24'h00_0002, {22'h0, vector_pull_n, addr_valid});
    t_abs;
    t_dir;
    t_ind;
    t_jump;
    t_imm_vec;
    t_move;
    tally_and_finish;
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
